/* logic/xpb_pkg.sv */
// external port buffer package: register map, field layout, packing codes
// assumes a 32-bit register port and a 48-bit internal word
package xpb_pkg;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] XPB_CTRL    = 8'h00;
	localparam logic [7:0] XPB_SECOND_MODE_REGISTER   = 8'h04;
	localparam logic [7:0] XPB_STATUS  = 8'h08;
	localparam logic [7:0] XPB_BUF_LO  = 8'h0C;
	localparam logic [7:0] XPB_BUF_HI  = 8'h10;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int XPB_PACK_LSB   = 0;
	localparam int XPB_SLV_EN_BIT = 3;
	localparam int XPB_MST_EN_BIT = 4;
	localparam int XPB_MST_DIR    = 5;
	localparam int XPB_LOCK_BIT   = 0;
	localparam logic [2:0]  XPB_PACK_RST = 3'h4;
	localparam logic [31:0] XPB_ZERO     = 32'h0000_0000;
	localparam int XPB_IW = 48;
	localparam int XPB_XW = 32;

	// ****************************************************************
	// packing select codes
	// ****************************************************************
	typedef enum logic [2:0] {
		XPB_P16_I32 = 3'b001,
		XPB_P16_I48 = 3'b010,
		XPB_P32_I48 = 3'b011,
		XPB_P32_I32 = 3'b100,
		XPB_P8_I48  = 3'b101,
		XPB_P8_I32  = 3'b110
	} xpb_pack_e;
endpackage : xpb_pkg

/* logic/xpb_stream_if.sv */
// external port buffer stream between the two-entry buffer and the packer
// assumes both ends on one clock
`timescale 1ns/1ps
`default_nettype none
interface xpb_stream_if;
	logic [47:0] data;
	logic        valid;
	logic        ready;
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface : xpb_stream_if
`default_nettype wire

/* logic/xpb_fifo2.sv */
// two-entry buffer for internal words
// assumes a synchronous push/pop handshake
`timescale 1ns/1ps
`default_nettype none
module xpb_fifo2 #(
	parameter int W = 48
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [1:0]        count_o,
	xpb_stream_if.src         out
);
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic         rd_ptr, next_rd_ptr;
	logic [1:0]   count, next_count;
	logic         push, pop;

	assign in_ready_o = (count != 2'h2);
	assign count_o    = count;
	assign out.valid  = (count != 2'h0);
	assign out.data   = mem[rd_ptr];
	assign push       = in_valid_i && in_ready_o;
	assign pop        = out.valid && out.ready;

	always_comb begin
		next_mem    = mem;
		next_rd_ptr = rd_ptr ^ pop;
		next_count  = count + {1'b0, push} - {1'b0, pop};
		if (push) begin
			next_mem[rd_ptr ^ count[0]] = in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem[0] <= '0;
			mem[1] <= '0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			mem    <= next_mem;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end
endmodule : xpb_fifo2
`default_nettype wire

/* logic/xpb_packer.sv */
// packer: splits one internal word into external beats per packing code
// assumes the packing code is steady while a word is being unpacked
`timescale 1ns/1ps
`default_nettype none
module xpb_packer
	import xpb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  pack_i,
	input  wire logic        take_i,
	output logic [31:0]      ext_data_o,
	output logic             ext_valid_o,
	xpb_stream_if.dst        in
);
	logic [47:0] shreg, next_shreg;
	logic [2:0]  beats, next_beats;
	logic [31:0] ext_data, next_ext_data;
	logic        ext_valid, next_ext_valid;
	logic [5:0]  w;
	logic [2:0]  n;
	logic        load;

	// beat width and count for the selected packing
	always_comb begin
		case (pack_i)
			XPB_P16_I32: begin w = 6'd16; n = 3'd2; end // RULE2
			XPB_P8_I32:  begin w = 6'd8;  n = 3'd4; end // RULE2
			XPB_P16_I48: begin w = 6'd16; n = 3'd3; end // RULE3
			XPB_P32_I48: begin w = 6'd32; n = 3'd2; end // RULE3
			XPB_P8_I48:  begin w = 6'd8;  n = 3'd6; end // RULE3
			default:     begin w = 6'd32; n = 3'd1; end // RULE1
		endcase
	end

	assign in.ready = !ext_valid;
	assign load     = in.valid && in.ready;

	always_comb begin
		logic [47:0] src;
		logic [47:0] msk;
		src            = load ? in.data : shreg;
		msk            = (48'h1 << w) - 48'h1;
		next_shreg     = shreg;
		next_beats     = beats;
		next_ext_data  = ext_data;
		next_ext_valid = ext_valid;
		if (load || (take_i && ext_valid && beats > 3'd1)) begin // RULE6
			next_ext_data  = 32'(src & msk);
			next_shreg     = src >> w;
			next_beats     = load ? n : beats - 3'd1;
			next_ext_valid = 1'b1;
		end else if (take_i && ext_valid) begin
			next_ext_valid = 1'b0;
			next_beats     = 3'd0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg     <= '0;
			beats     <= 3'd0;
			ext_data  <= XPB_ZERO;
			ext_valid <= 1'b0;
		end else begin
			shreg     <= next_shreg;
			beats     <= next_beats;
			ext_data  <= next_ext_data;
			ext_valid <= next_ext_valid;
		end
	end

	assign ext_data_o  = ext_data;
	assign ext_valid_o = ext_valid;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_no_pack_word: assert property (load && pack_i == 3'b100 |=> // RULE1
		ext_data == $past(in.data[31:0]) && beats == 3'd1)
		else $error("no-pack word not passed whole");
	a_wide_internal: assert property (load && (pack_i == 3'b001 || pack_i == 3'b110) // RULE2
		|=> beats == (($past(pack_i) == 3'b001) ? 3'd2 : 3'd4))
		else $error("32-bit internal word beat count wrong");
	a_narrow_48: assert property (load && pack_i == 3'b101 |=> beats == 3'd6 // RULE3
		&& ext_data == {24'h0, $past(in.data[7:0])})
		else $error("8/48 packing wrong");
	a_beat_once: assert property (take_i && ext_valid && beats > 3'd1 |=> // RULE6
		ext_valid && ext_data == 32'($past(shreg) & ((48'h1 << $past(w)) - 48'h1)))
		else $error("beat repeated or skipped");
endmodule : xpb_packer
`default_nettype wire

/* logic/xpb_port.sv */
// external port buffer top: register port, core/dma fill, host read, bus lock
// assumes one 10 MHz clock, registers reached by a plain strobe port
//
// Operation
// [RULE1] code 100 sends one 32-bit word each
// [RULE2] codes 001, 100, 110 use 32-bit internal
// [RULE3] 48-bit internal: 010 x16, 011 x32, 101 x8
// [RULE4] device fills buffer, host reads it out
// [RULE5] master dma may run beside slave dma
// [RULE6] host gets each word once, in order
// [RULE7] lock bit requests bus, owner flag pollable
// [RULE8] locked owner keeps others off the bus
// [RULE9] core may write buffer words directly
// [RULE10] dma channels can be disabled and re-enabled
// [RULE11] core writes serialised with dma pushes
`timescale 1ns/1ps
`default_nettype none
module xpb_port (
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic [31:0]      RDATA_O,
	input  wire logic [47:0] DMA_DATA_I,
	input  wire logic        DMA_VALID_I,
	output logic             DMA_READY_O,
	input  wire logic        HOST_RD_I,
	output logic [31:0]      HOST_DATA_O,
	output logic             HOST_VALID_O,
	input  wire logic        BUS_GRANT_I,
	output logic             BUS_REQ_O,
	output logic             BUS_LOCK_O,
	output logic             MDMA_ACTIVE_O,
	output logic             MDMA_DIR_O
);
	import xpb_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	logic [2:0]  packing_select_field, next_packing_select_field;
	logic        slave_en, next_slave_en;
	logic        master_en, next_master_en;
	logic        master_dir, next_master_dir;
	logic        bus_lock_bit, next_bus_lock_bit;
	logic        bus_owner_flag, next_bus_owner_flag;
	logic        bus_req, next_bus_req;
	logic        bus_lock_out, next_bus_lock_out;
	logic        mdma_active, next_mdma_active;
	logic [15:0] buf_hi, next_buf_hi;
	logic [47:0] core_word, next_core_word;
	logic        core_pending, next_core_pending;
	logic        dma_ready, next_dma_ready;
	logic [31:0] rdata, next_rdata;

	logic [47:0] push_data;
	logic        push_valid;
	logic        push_ready;
	logic [1:0]  fill;
	logic        dma_push;
	logic        core_push;
	logic        core_wr;

	xpb_stream_if st ();

	// ****************************************************************
	// fill path: dma has the slot it was offered, core word goes next
	// ****************************************************************
	assign dma_push   = DMA_VALID_I && dma_ready;                  // RULE4
	assign core_push  = core_pending && !dma_push && push_ready;   // RULE11
	assign push_valid = dma_push || core_push;
	assign push_data  = dma_push ? DMA_DATA_I : core_word;
	assign core_wr    = WR_I && ADDR_I == XPB_BUF_LO;

	xpb_fifo2 #(
		.W (XPB_IW)
	) u_fifo (
		.clk_i      (CLK_I),
		.rst_i      (RESET_I),
		.in_data_i  (push_data),
		.in_valid_i (push_valid),
		.in_ready_o (push_ready),
		.count_o    (fill),
		.out        (st.src)
	);

	xpb_packer u_pack (
		.clk_i       (CLK_I),
		.rst_i       (RESET_I),
		.pack_i      (packing_select_field),
		.take_i      (HOST_RD_I),
		.ext_data_o  (HOST_DATA_O),
		.ext_valid_o (HOST_VALID_O),
		.in          (st.dst)
	);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		logic [1:0] fill_after;
		fill_after                = fill + {1'b0, push_valid} - {1'b0, st.valid && st.ready};
		next_packing_select_field = packing_select_field;
		next_slave_en             = slave_en;
		next_master_en            = master_en;
		next_master_dir           = master_dir;
		next_bus_lock_bit         = bus_lock_bit;
		next_buf_hi               = buf_hi;
		next_core_word            = core_word;
		next_core_pending         = core_pending && !core_push;
		next_rdata                = XPB_ZERO;
		if (WR_I) begin
			case (ADDR_I)
				XPB_CTRL: begin
					next_packing_select_field = WDATA_I[XPB_PACK_LSB +: 3];
					next_slave_en             = WDATA_I[XPB_SLV_EN_BIT];  // RULE10
					next_master_en            = WDATA_I[XPB_MST_EN_BIT];  // RULE5
					next_master_dir           = WDATA_I[XPB_MST_DIR];
				end
				XPB_SECOND_MODE_REGISTER:  next_bus_lock_bit = WDATA_I[XPB_LOCK_BIT];
				XPB_BUF_HI: next_buf_hi = WDATA_I[15:0];
				XPB_BUF_LO: begin
					if (!core_pending) begin
						next_core_word    = {buf_hi, WDATA_I};          // RULE9
						next_core_pending = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (RD_I) begin
			case (ADDR_I)
				XPB_CTRL:   next_rdata = {26'h0, master_dir, master_en, slave_en,
					packing_select_field};
				XPB_SECOND_MODE_REGISTER:  next_rdata = {31'h0, bus_lock_bit};
				XPB_STATUS: next_rdata = {27'h0, HOST_VALID_O, fill, core_pending,
					bus_owner_flag};                                    // RULE7
				XPB_BUF_HI: next_rdata = {16'h0, buf_hi};
				default:    next_rdata = XPB_ZERO;
			endcase
		end
		// slave dma offered a slot only when the buffer is empty and no core word waits
		next_dma_ready      = next_slave_en && !next_core_pending
			&& fill_after == 2'h0;                                      // RULE11
		next_bus_req        = next_bus_lock_bit || next_master_en;     // RULE7
		next_bus_owner_flag = bus_req && BUS_GRANT_I;
		next_bus_lock_out   = bus_lock_bit && bus_owner_flag;          // RULE8
		next_mdma_active    = master_en && bus_owner_flag;             // RULE5
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			packing_select_field <= XPB_PACK_RST;
			slave_en             <= 1'b0;
			master_en            <= 1'b0;
			master_dir           <= 1'b0;
			bus_lock_bit         <= 1'b0;
			bus_owner_flag       <= 1'b0;
			bus_req              <= 1'b0;
			bus_lock_out         <= 1'b0;
			mdma_active          <= 1'b0;
			buf_hi               <= 16'h0000;
			core_word            <= 48'h0000_0000_0000;
			core_pending         <= 1'b0;
			dma_ready            <= 1'b0;
			rdata                <= XPB_ZERO;
		end else begin
			packing_select_field <= next_packing_select_field;
			slave_en             <= next_slave_en;
			master_en            <= next_master_en;
			master_dir           <= next_master_dir;
			bus_lock_bit         <= next_bus_lock_bit;
			bus_owner_flag       <= next_bus_owner_flag;
			bus_req              <= next_bus_req;
			bus_lock_out         <= next_bus_lock_out;
			mdma_active          <= next_mdma_active;
			buf_hi               <= next_buf_hi;
			core_word            <= next_core_word;
			core_pending         <= next_core_pending;
			dma_ready            <= next_dma_ready;
			rdata                <= next_rdata;
		end
	end

	assign RDATA_O       = rdata;
	assign DMA_READY_O   = dma_ready;
	assign BUS_REQ_O     = bus_req;
	assign BUS_LOCK_O    = bus_lock_out;
	assign MDMA_ACTIVE_O = mdma_active;
	assign MDMA_DIR_O    = master_dir;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_lock_set;
		WR_I && ADDR_I == XPB_SECOND_MODE_REGISTER && WDATA_I[0];
	endsequence
	sequence s_req_then_grant;
		BUS_REQ_O ##0 BUS_GRANT_I;
	endsequence

	a_lock_request: assert property (s_lock_set |=> BUS_REQ_O) // RULE7
		else $error("bus lock did not request the bus");
	a_owner_flag: assert property (s_req_then_grant |=> bus_owner_flag) // RULE7
		else $error("owner flag missed grant");
	a_lock_keeps_bus: assert property (bus_lock_bit && bus_owner_flag |=> BUS_LOCK_O) // RULE8
		else $error("locked owner not holding bus");
	a_dma_disabled: assert property (WR_I && ADDR_I == XPB_CTRL && !WDATA_I[3] // RULE10
		|=> !DMA_READY_O [*2])
		else $error("disabled dma still offered a slot");
	a_core_first: assert property (core_pending && !core_push |=> !DMA_READY_O) // RULE11
		else $error("dma offered while core word waits");
	a_core_capture: assert property (core_wr && !core_pending |=> core_pending // RULE9
		&& core_word[31:0] == $past(WDATA_I))
		else $error("core buffer write lost");
	a_no_overrun: assert property (push_valid |-> push_ready) // RULE6
		else $error("push into full buffer");
	a_master_beside: assert property (master_en && bus_owner_flag && slave_en // RULE5
		&& !(WR_I && ADDR_I == XPB_CTRL) |=> MDMA_ACTIVE_O && slave_en)
		else $error("master dma blocked by slave dma");

	// ****************************************************************
	// register port checks
	// ****************************************************************
	sequence s_ctrl_write;
		WR_I && ADDR_I == XPB_CTRL;
	endsequence
	sequence s_status_read;
		RD_I && ADDR_I == XPB_STATUS;
	endsequence

	a_pack_write: assert property (s_ctrl_write |=> // RULE2
		packing_select_field == $past(WDATA_I[2:0]))
		else $error("packing code not taken");
	a_slave_enable: assert property (s_ctrl_write ##0 WDATA_I[3] |=> slave_en) // RULE10
		else $error("slave dma not enabled");
	a_slave_disable: assert property (s_ctrl_write ##0 !WDATA_I[3] |=> !slave_en) // RULE10
		else $error("slave dma not disabled");
	a_master_enable: assert property (s_ctrl_write |=> // RULE5
		master_en == $past(WDATA_I[4]))
		else $error("master dma enable not taken");
	a_dir_bit: assert property (s_ctrl_write |=> MDMA_DIR_O == $past(WDATA_I[5])) // RULE5
		else $error("master dma direction not taken");
	a_lock_write: assert property (WR_I && ADDR_I == XPB_SECOND_MODE_REGISTER |=> // RULE7
		bus_lock_bit == $past(WDATA_I[0]))
		else $error("lock bit not taken");
	a_lock_readback: assert property (RD_I && ADDR_I == XPB_SECOND_MODE_REGISTER |=> // RULE7
		RDATA_O == {31'h0, $past(bus_lock_bit)})
		else $error("lock bit read back wrong");
	a_owner_status: assert property (s_status_read |=> // RULE7
		RDATA_O[0] == $past(bus_owner_flag))
		else $error("owner flag read back wrong");
	a_core_status: assert property (s_status_read |=> // RULE9
		RDATA_O[1] == $past(core_pending))
		else $error("core pending read back wrong");
	a_valid_status: assert property (s_status_read |=> // RULE4
		RDATA_O[4] == $past(HOST_VALID_O))
		else $error("host valid read back wrong");
	a_write_only: assert property (RD_I && ADDR_I == XPB_BUF_LO |=> RDATA_O == XPB_ZERO)
		else $error("write-only buffer read not zero");
	a_read_idle: assert property (!RD_I |=> RDATA_O == XPB_ZERO)
		else $error("read data held past its cycle");

	// ****************************************************************
	// bus ownership checks
	// ****************************************************************
	sequence s_lock_grant;
		bus_lock_bit && BUS_REQ_O && BUS_GRANT_I ##1 bus_lock_bit;
	endsequence

	a_lock_chain: assert property (s_lock_grant |=> BUS_LOCK_O) // RULE8
		else $error("granted lock not held");
	a_lock_release: assert property (!bus_lock_bit |=> !BUS_LOCK_O) // RULE8
		else $error("bus held after lock release");
	a_req_idle: assert property (!bus_lock_bit && !master_en && !WR_I |=> !BUS_REQ_O) // RULE7
		else $error("bus requested with no cause");
	a_owner_grant: assert property (!BUS_GRANT_I |=> !bus_owner_flag) // RULE7
		else $error("owner flag without grant");
	a_mdma_owner: assert property (!bus_owner_flag |=> !MDMA_ACTIVE_O) // RULE5
		else $error("master dma active without bus");
	a_mdma_start: assert property (master_en && bus_owner_flag |=> MDMA_ACTIVE_O) // RULE5
		else $error("master dma not started");

	// ****************************************************************
	// fill path checks
	// ****************************************************************
	a_fill_bound: assert property (fill != 2'h3) // RULE6
		else $error("buffer fill out of range");
	a_one_take: assert property (DMA_VALID_I && DMA_READY_O |=> !DMA_READY_O) // RULE6
		else $error("dma slot offered twice");
	a_slot_busy: assert property (fill != 2'h0 && !st.ready |=> !DMA_READY_O) // RULE6
		else $error("dma slot offered while buffer busy");
	a_dma_first: assert property (dma_push && core_pending |=> core_pending) // RULE11
		else $error("core word pushed beside dma word");
	a_busy_refused: assert property (core_wr && core_pending |=> // RULE11
		core_word == $past(core_word))
		else $error("pending core word overwritten");
	a_core_leaves: assert property (core_push |=> !core_pending) // RULE9
		else $error("core word pushed but still pending");
	a_core_word: assert property (core_wr && !core_pending |=> // RULE9
		core_word[47:32] == $past(buf_hi))
		else $error("core word upper part lost");
	a_buf_hi_keep: assert property (!(WR_I && ADDR_I == XPB_BUF_HI) |=> // RULE9
		buf_hi == $past(buf_hi))
		else $error("upper buffer half not sticky");
endmodule : xpb_port
`default_nettype wire

/* bench/xpb_host_model.sv */
// host reader and bus arbiter on the far side of the external port buffer
// assumes registered port outputs and one shared clock
`timescale 1ns/1ps
`default_nettype none
module xpb_host_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] data_i,
	input  wire logic        valid_i,
	input  wire logic        req_i,
	input  wire logic        stall_i,
	output logic             rd_o,
	output logic             grant_o
);
	logic [31:0] got[$];
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_o <= 1'b0;
			grant_o <= 1'b0;
		end else begin
			if (rd_o && valid_i) begin
				got.push_back(data_i);
			end
			rd_o <= valid_i && !stall_i && !rd_o;
			grant_o <= req_i;
		end
	end
endmodule : xpb_host_model
`default_nettype wire

/* bench/xpb_port_tb.sv */
// self-checking bench for the external port buffer top
// assumes the host model as far side and arbiter
`timescale 1ns/1ps
`default_nettype none
module xpb_port_tb;
	import xpb_pkg::*;
	logic CLK_I = 0, RESET_I = 1, WR_I = 0, RD_I = 0, DMA_VALID_I = 0, stall = 0;
	logic [7:0] ADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0, RDATA_O, HOST_DATA_O, v;
	logic [47:0] DMA_DATA_I = 48'h0;
	logic DMA_READY_O, HOST_RD_I, HOST_VALID_O, BUS_GRANT_I, BUS_REQ_O;
	logic BUS_LOCK_O, MDMA_ACTIVE_O, MDMA_DIR_O;
	logic [31:0] expq[$];
	int fails = 0, tests_run = 0;
	always #50 CLK_I = ~CLK_I;
	xpb_port i_dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DMA_DATA_I(DMA_DATA_I),
		.DMA_VALID_I(DMA_VALID_I), .DMA_READY_O(DMA_READY_O), .HOST_RD_I(HOST_RD_I),
		.HOST_DATA_O(HOST_DATA_O), .HOST_VALID_O(HOST_VALID_O), .BUS_GRANT_I(BUS_GRANT_I),
		.BUS_REQ_O(BUS_REQ_O), .BUS_LOCK_O(BUS_LOCK_O), .MDMA_ACTIVE_O(MDMA_ACTIVE_O),
		.MDMA_DIR_O(MDMA_DIR_O));
	xpb_host_model i_host (.clk_i(CLK_I), .rst_i(RESET_I), .data_i(HOST_DATA_O),
		.valid_i(HOST_VALID_O), .req_i(BUS_REQ_O), .stall_i(stall), .rd_o(HOST_RD_I),
		.grant_o(BUS_GRANT_I));
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		@(posedge CLK_I);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 d = RDATA_O;
		@(posedge CLK_I);
	endtask : rd
	task automatic push(input logic [47:0] w);
		int n;
		DMA_DATA_I <= w;
		DMA_VALID_I <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_I);
			n++;
		end while (!DMA_READY_O && n < 400);
		DMA_VALID_I <= 1'b0;
		if (n >= 400) chk(32'h1, 32'h0);
		@(posedge CLK_I);
	endtask : push
	task automatic expect_word(input logic [2:0] p, input logic [47:0] w);
		int n, b;
		logic [63:0] x;
		x = (p == 3'h1 || p == 3'h4 || p == 3'h6) ? {32'h0, w[31:0]} : {16'h0, w};
		case (p)
			3'h1: begin n = 2; b = 16; end
			3'h6: begin n = 4; b = 8; end
			3'h2: begin n = 3; b = 16; end
			3'h3: begin n = 2; b = 32; end
			3'h5: begin n = 6; b = 8; end
			default: begin n = 1; b = 32; end
		endcase
		for (int i = 0; i < n; i++) expq.push_back(32'((x >> (i * b)) & ((64'h1 << b) - 1)));
	endtask : expect_word
	task automatic drain();
		int n;
		n = 0;
		while (i_host.got.size() < expq.size() && n < 2000) begin
			@(posedge CLK_I);
			n++;
		end
		repeat (4) @(posedge CLK_I);
		chk(32'(i_host.got.size()), 32'(expq.size()));
		foreach (expq[i]) if (i < i_host.got.size()) chk(i_host.got[i], expq[i]);
		expq.delete();
		i_host.got.delete();
	endtask : drain
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		chk({31'h0, HOST_VALID_O}, 32'h0);
		chk({31'h0, DMA_READY_O}, 32'h0);
		rd(XPB_CTRL, v);
		chk(v, 32'h4);
		rd(XPB_STATUS, v);
		chk(v, 32'h0);
		rd(XPB_SECOND_MODE_REGISTER, v);
		chk(v, 32'h0);
		rd(8'hFC, v);
		chk(v, 32'h0);
	endtask : t_reset
	task automatic t_modes();
		logic [2:0] codes[6] = '{3'h4, 3'h1, 3'h6, 3'h2, 3'h3, 3'h5};
		foreach (codes[i]) begin
			wr(XPB_CTRL, {28'h0, 1'b1, codes[i]});
			push(48'hA1B2_C3D4_E5F6);
			expect_word(codes[i], 48'hA1B2_C3D4_E5F6);
			push(48'h1122_3344_5566);
			expect_word(codes[i], 48'h1122_3344_5566);
			drain();
		end
	endtask : t_modes
	task automatic t_core();
		wr(XPB_CTRL, 32'h4);
		wr(XPB_BUF_HI, 32'h0000_00AB);
		rd(XPB_BUF_HI, v);
		chk(v, 32'h0000_00AB);
		wr(XPB_BUF_LO, 32'h0000_0010);
		expect_word(3'h4, 48'hAB_0000_0010);
		drain();
	endtask : t_core
	task automatic t_lock();
		int n;
		wr(XPB_SECOND_MODE_REGISTER, 32'h1);
		n = 0;
		do begin
			rd(XPB_STATUS, v);
			n++;
		end while (v[0] !== 1'b1 && n < 10);
		chk({31'h0, v[0]}, 32'h1);
		chk({31'h0, BUS_LOCK_O}, 32'h1);
		wr(XPB_CTRL, 32'h3C);
		@(posedge CLK_I);
		chk({31'h0, MDMA_ACTIVE_O}, 32'h1);
		chk({31'h0, MDMA_DIR_O}, 32'h1);
		chk({31'h0, BUS_REQ_O}, 32'h1);
		rd(XPB_CTRL, v);
		chk(v, 32'h3C);
		stall <= 1'b1;
		fork
			for (int i = 1; i <= 6; i++) begin
				push(48'(i * 16));
				expect_word(3'h4, 48'(i * 16));
			end
			begin
				repeat (30) @(posedge CLK_I);
				stall <= 1'b0;
			end
		join
		drain();
		chk({31'h0, BUS_LOCK_O}, 32'h1);
		wr(XPB_CTRL, 32'h4);
		wr(XPB_SECOND_MODE_REGISTER, 32'h0);
		repeat (3) @(posedge CLK_I);
		chk({31'h0, BUS_LOCK_O}, 32'h0);
		chk({31'h0, BUS_REQ_O}, 32'h0);
		chk({31'h0, MDMA_DIR_O}, 32'h0);
	endtask : t_lock
	task automatic t_mix();
		wr(XPB_CTRL, 32'h1C);
		fork
			push(48'h0000_0000_0050);
			wr(XPB_BUF_LO, 32'h0000_0060);
		join
		wr(XPB_CTRL, 32'h04);
		chk({31'h0, DMA_READY_O}, 32'h0);
		wr(XPB_BUF_LO, 32'h0000_0070);
		wr(XPB_CTRL, 32'h0C);
		push(48'h0000_0000_0080);
		repeat (40) @(posedge CLK_I);
		chk(32'(i_host.got.size()), 32'h4);
		chk(i_host.got[0] ^ i_host.got[1], 32'h0030);
		chk(i_host.got[2], 32'h0070);
		chk(i_host.got[3], 32'h0080);
		i_host.got.delete();
	endtask : t_mix
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		#(40000 * 100);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge CLK_I);
		RESET_I <= 1'b0;
		@(posedge CLK_I);
		t_reset();
		t_core();
		t_modes();
		t_lock();
		t_mix();
		tally_and_finish();
	end
endmodule : xpb_port_tb
`default_nettype wire
